// [core/exc_pkg.sv]
/*
 * constants, states and port structs of the exception and reset unit.
 * assumes a single 40 MHz clock shared by the core, the system bus and the register bus.
 */
package exc_pkg;

  // ***************************************
  // register map
  // ***************************************
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_VBASE = 8'h04;
  localparam logic [7:0] A_AVSEL = 8'h08;
  localparam logic [7:0] A_LMEM = 8'h0c;
  localparam logic [7:0] A_STATE = 8'h10;
  localparam logic [7:0] A_SP = 8'h14;
  localparam logic [7:0] A_PC = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************
  // status word, vectors, addresses
  // ***************************************
  localparam int SR_T = 15;
  localparam int SR_S = 13;
  localparam int SR_M = 12;
  localparam int SR_IPL = 8;
  localparam logic [2:0] IPL_MAX = 3'h7;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_SP = 32'h0000_0000;
  localparam logic [31:0] ADDR_PC = 32'h0000_0004;
  localparam logic [7:0] VEC_ACCESS = 8'h02;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] VEC_UNSUP = 8'h61;
  localparam int LMEM_N = 4;

  typedef enum logic [6:0] {
    ST_RESET = 7'h01,
    ST_FETCH_SP = 7'h02,
    ST_FETCH_PC = 7'h04,
    ST_RUN = 7'h08,
    ST_IACK = 7'h10,
    ST_VECT = 7'h20,
    ST_HALT = 7'h40
  } exc_state_t;

  // ***************************************
  // port structs
  // ***************************************
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic valid;
    logic iack;
    logic [31:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] data;
  } bus_rsp_t;

  typedef struct packed {
    logic instr_done;
    logic unsupported_op;
    logic fault;
  } core_in_t;

  typedef struct packed {
    logic running;
    logic halted;
    logic in_reset;
    logic redirect;
    logic [31:0] redirect_pc;
    logic [31:0] stack_ptr;
    logic [7:0] vector;
    logic [LMEM_N-1:0] lmem_enable;
    logic [15:0] status_word;
  } core_out_t;

endpackage

// [core/exc_unit.sv]
/*
 * exception and reset unit: reset sequence, interrupt and vector fetch, unsupported opcode,
 * trace and fault-on-fault halt, with an AXI4-Lite register slave.
 * assumes the system bus and core run on aclk; reset_in_n and irq_level are asynchronous pins.
 */
`timescale 1ns/10ps
module exc_unit (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic reset_in_n,
  input wire logic [2:0] irq_level,
  // register bus
  input wire exc_pkg::axil_req_t s_in,
  output exc_pkg::axil_rsp_t s_out,
  // system bus read master
  output exc_pkg::bus_req_t bus_out,
  input wire exc_pkg::bus_rsp_t bus_in,
  // core
  input wire exc_pkg::core_in_t core_in,
  output exc_pkg::core_out_t core_out
);

  typedef struct packed {
    exc_pkg::exc_state_t st;
    logic [15:0] sr;
    logic [31:0] vector_base;
    logic [7:0] avsel;
    logic [exc_pkg::LMEM_N-1:0] lmem;
    logic [7:0] vec;
    logic booted;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    exc_pkg::axil_rsp_t s;
    exc_pkg::bus_req_t bus;
    exc_pkg::core_out_t co;
  } unit_state_t;

  unit_state_t r;
  unit_state_t next_r;
  logic [3:0] pins_s;
  logic rst_s;
  logic [2:0] lvl_s;

  // ***************************************
  // pin synchronisers
  // ***************************************
  pin_sync #(.W(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({reset_in_n, irq_level}),
    .q(pins_s)
  );
  assign rst_s = pins_s[3];
  assign lvl_s = pins_s[2:0];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    logic [31:0] wm;
    logic go_vect;
    logic [7:0] vsel;
    logic irq_take;
    wm = 32'h0;
    go_vect = 1'b0;
    vsel = r.vec;
    irq_take = (lvl_s == exc_pkg::IPL_MAX) || (lvl_s > r.sr[exc_pkg::SR_IPL +: 3]);
    next_r = r;
    next_r.co.redirect = 1'b0;

    // register bus: address and data taken in either order
    if (s_in.awvalid && r.s.awready) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_in.awaddr;
    end
    if (s_in.wvalid && r.s.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_in.wdata;
      next_r.wstrb = s_in.wstrb;
    end
    if (r.s.bvalid && s_in.bready) begin
      next_r.s.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.s.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.s.bvalid = 1'b1;
      next_r.s.bresp = exc_pkg::RESP_OKAY;
      case (r.aw_addr)
        exc_pkg::A_STATUS: begin
          wm = merge({16'h0, r.sr}, r.wdata, r.wstrb);
          next_r.sr = wm[15:0];
        end
        exc_pkg::A_VBASE: begin
          next_r.vector_base = merge(r.vector_base, r.wdata, r.wstrb);
        end
        exc_pkg::A_AVSEL: begin
          wm = merge({24'h0, r.avsel}, r.wdata, r.wstrb);
          next_r.avsel = wm[7:0];
        end
        exc_pkg::A_LMEM: begin
          wm = merge({28'h0, r.lmem}, r.wdata, r.wstrb);
          next_r.lmem = wm[exc_pkg::LMEM_N-1:0];
        end
        exc_pkg::A_STATE, exc_pkg::A_SP, exc_pkg::A_PC: begin
          next_r.s.bresp = exc_pkg::RESP_OKAY;
        end
        default: begin
          next_r.s.bresp = exc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (r.s.rvalid && s_in.rready) begin
      next_r.s.rvalid = 1'b0;
    end
    if (s_in.arvalid && r.s.arready) begin
      next_r.s.rvalid = 1'b1;
      next_r.s.rresp = exc_pkg::RESP_OKAY;
      case (s_in.araddr)
        exc_pkg::A_STATUS: next_r.s.rdata = {16'h0, r.sr};
        exc_pkg::A_VBASE: next_r.s.rdata = r.vector_base;
        exc_pkg::A_AVSEL: next_r.s.rdata = {24'h0, r.avsel};
        exc_pkg::A_LMEM: next_r.s.rdata = {28'h0, r.lmem};
        exc_pkg::A_STATE: next_r.s.rdata = {15'h0, r.booted, r.vec, 1'b0, r.st};
        exc_pkg::A_SP: next_r.s.rdata = r.co.stack_ptr;
        exc_pkg::A_PC: next_r.s.rdata = r.co.redirect_pc;
        default: begin
          next_r.s.rdata = 32'h0;
          next_r.s.rresp = exc_pkg::RESP_SLVERR;
        end
      endcase
    end

    // exception sequencer; hardware updates follow register writes so they win
    case (r.st)
      exc_pkg::ST_RESET: begin
        next_r.st = exc_pkg::ST_FETCH_SP;
        next_r.bus.valid = 1'b1;
        next_r.bus.iack = 1'b0;
        next_r.bus.addr = exc_pkg::ADDR_SP;
      end
      exc_pkg::ST_FETCH_SP: begin
        if (core_in.fault || (bus_in.valid && bus_in.err)) begin
          next_r.st = exc_pkg::ST_HALT;
          next_r.bus.valid = 1'b0;
        end else if (bus_in.valid) begin
          next_r.co.stack_ptr = bus_in.data;
          next_r.bus.addr = exc_pkg::ADDR_PC;
          next_r.st = exc_pkg::ST_FETCH_PC;
        end
      end
      exc_pkg::ST_FETCH_PC: begin
        if (core_in.fault || (bus_in.valid && bus_in.err)) begin
          next_r.st = exc_pkg::ST_HALT;
          next_r.bus.valid = 1'b0;
        end else if (bus_in.valid) begin
          next_r.co.redirect_pc = bus_in.data;
          next_r.co.redirect = 1'b1;
          next_r.bus.valid = 1'b0;
          next_r.st = exc_pkg::ST_RUN;
        end
      end
      exc_pkg::ST_RUN: begin
        if (core_in.fault && !r.booted) begin
          next_r.st = exc_pkg::ST_HALT;
        end else if (core_in.fault) begin
          go_vect = 1'b1;
          vsel = exc_pkg::VEC_ACCESS;
        end else if (core_in.unsupported_op) begin
          go_vect = 1'b1;
          vsel = exc_pkg::VEC_UNSUP;
        end else if (core_in.instr_done && r.sr[exc_pkg::SR_T]) begin
          go_vect = 1'b1;
          vsel = exc_pkg::VEC_TRACE;
        end else if (irq_take) begin
          next_r.sr[exc_pkg::SR_IPL +: 3] = lvl_s;
          next_r.sr[exc_pkg::SR_S] = 1'b1;
          next_r.sr[exc_pkg::SR_T] = 1'b0;
          if (r.avsel[lvl_s]) begin
            go_vect = 1'b1;
            vsel = exc_pkg::VEC_AUTO_BASE + {5'h0, lvl_s};
          end else begin
            next_r.st = exc_pkg::ST_IACK;
            next_r.bus.valid = 1'b1;
            next_r.bus.iack = 1'b1;
            next_r.bus.addr = {29'h0, lvl_s};
          end
        end
        if (core_in.instr_done) begin
          next_r.booted = 1'b1;
        end
      end
      exc_pkg::ST_IACK: begin
        if (core_in.fault) begin
          next_r.st = exc_pkg::ST_HALT;
          next_r.bus.valid = 1'b0;
        end else if (bus_in.valid) begin
          go_vect = 1'b1;
          vsel = bus_in.err ? exc_pkg::VEC_SPURIOUS : bus_in.data[7:0];
        end
      end
      exc_pkg::ST_VECT: begin
        if (core_in.fault || (bus_in.valid && bus_in.err)) begin
          next_r.st = exc_pkg::ST_HALT;
          next_r.bus.valid = 1'b0;
        end else if (bus_in.valid) begin
          next_r.co.redirect_pc = bus_in.data;
          next_r.co.redirect = 1'b1;
          next_r.bus.valid = 1'b0;
          next_r.st = exc_pkg::ST_RUN;
        end
      end
      exc_pkg::ST_HALT: begin
        next_r.st = exc_pkg::ST_HALT;
      end
      default: begin
        next_r.st = exc_pkg::ST_HALT;
      end
    endcase
    if (go_vect) begin
      if (r.st == exc_pkg::ST_RUN) begin
        next_r.sr[exc_pkg::SR_S] = 1'b1;
        next_r.sr[exc_pkg::SR_T] = 1'b0;
      end
      next_r.vec = vsel;
      next_r.st = exc_pkg::ST_VECT;
      next_r.bus.valid = 1'b1;
      next_r.bus.iack = 1'b0;
      next_r.bus.addr = r.vector_base + {22'h0, vsel, 2'b00};
    end

    // reset input overrides the sequencer, status bits, vector base and local memories and drops work in flight
    if (!rst_s) begin
      next_r.st = exc_pkg::ST_RESET;
      next_r.bus.valid = 1'b0;
      next_r.bus.iack = 1'b0;
      next_r.booted = 1'b0;
      next_r.co.redirect = 1'b0;
      next_r.sr[exc_pkg::SR_S] = 1'b1;
      next_r.sr[exc_pkg::SR_T] = 1'b0;
      next_r.sr[exc_pkg::SR_M] = 1'b0;
      next_r.sr[exc_pkg::SR_IPL +: 3] = exc_pkg::IPL_MAX;
      next_r.vector_base = exc_pkg::VBR_RESET;
      next_r.lmem = '0;
    end

    next_r.s.awready = !next_r.aw_got && !next_r.s.bvalid;
    next_r.s.wready = !next_r.w_got && !next_r.s.bvalid;
    next_r.s.arready = !next_r.s.rvalid;
    next_r.co.running = (next_r.st == exc_pkg::ST_RUN);
    next_r.co.halted = (next_r.st == exc_pkg::ST_HALT);
    next_r.co.in_reset = (next_r.st == exc_pkg::ST_RESET);
    next_r.co.vector = next_r.vec;
    next_r.co.lmem_enable = next_r.lmem;
    next_r.co.status_word = next_r.sr;
  end

  // ***************************************
  // state register
  // ***************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= exc_pkg::ST_RESET;
      r.co.in_reset <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_out = r.s;
  assign bus_out = r.bus;
  assign core_out = r.co;

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_release;
    !rst_s ##1 rst_s;
  endsequence
  sequence s_fetch_sp;
    ##1 (r.st == exc_pkg::ST_FETCH_SP && r.bus.valid && r.bus.addr == exc_pkg::ADDR_SP);
  endsequence

  a_reset_abort: assert property (!rst_s |=> r.st == exc_pkg::ST_RESET && !r.bus.valid)
    else $error("reset did not abort processing");
  a_reset_status: assert property (!rst_s |=> r.sr[exc_pkg::SR_S] && !r.sr[exc_pkg::SR_T])
    else $error("reset status supervisor or trace wrong");
  a_reset_mask: assert property (!rst_s |=> !r.sr[exc_pkg::SR_M] && r.sr[exc_pkg::SR_IPL +: 3] == exc_pkg::IPL_MAX)
    else $error("reset mask or master bit wrong");
  a_reset_base: assert property (!rst_s |=> r.vector_base == exc_pkg::VBR_RESET && r.lmem == '0 && !r.booted)
    else $error("reset base or local memories not cleared");
  a_boot_fetch: assert property (s_release |-> s_fetch_sp)
    else $error("no stack pointer fetch after reset release");
  a_pc_loaded: assert property (r.st == exc_pkg::ST_FETCH_PC && bus_in.valid && !bus_in.err && !core_in.fault
      && rst_s |=> r.co.redirect && r.co.redirect_pc == $past(bus_in.data) && r.st == exc_pkg::ST_RUN)
    else $error("program counter not loaded from second read");
  a_boot_fault: assert property ((r.st == exc_pkg::ST_FETCH_SP || r.st == exc_pkg::ST_FETCH_PC)
      && bus_in.valid && bus_in.err && rst_s |=> r.co.halted)
    else $error("boot fault did not halt");
  a_double_fault: assert property ((r.st == exc_pkg::ST_IACK || r.st == exc_pkg::ST_VECT) && core_in.fault
      && rst_s |=> r.st == exc_pkg::ST_HALT)
    else $error("fault during exception did not halt");
  a_halt_hold: assert property (r.st == exc_pkg::ST_HALT && rst_s |=> r.st == exc_pkg::ST_HALT)
    else $error("left halt without reset");
  a_unsup_vector: assert property (r.st == exc_pkg::ST_RUN && rst_s && core_in.unsupported_op && !core_in.fault
      |=> r.vec == exc_pkg::VEC_UNSUP && r.bus.valid)
    else $error("unsupported opcode vector wrong");
  a_trace_exc: assert property (r.st == exc_pkg::ST_RUN && rst_s && core_in.instr_done && r.sr[exc_pkg::SR_T]
      && !core_in.fault && !core_in.unsupported_op |=> r.vec == exc_pkg::VEC_TRACE)
    else $error("trace exception missing");
  a_vector_addr: assert property ($rose(r.st == exc_pkg::ST_VECT)
      |-> r.bus.addr == $past(r.vector_base) + {22'h0, r.vec, 2'b00})
    else $error("vector table address wrong");

endmodule

// [core/pin_sync.sv]
/*
 * two flip-flop synchroniser, one chain per bit.
 * assumes the inputs are asynchronous pins; outputs read as zero while aresetn is low.
 */
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ***************************************
  // per-bit chains
  // ***************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta <= d[i];
        q[i] <= meta;
      end
    end
  end

endmodule

// [dv/sys_bus_model.sv]
/*
 * system bus read slave: answers each read after a set delay, with an optional error on one address.
 * assumes requests hold until answered and share aclk and aresetn with the unit.
 */
`timescale 1ns/10ps
module sys_bus_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // system bus
  input wire exc_pkg::bus_req_t req,
  output exc_pkg::bus_rsp_t rsp,
  // behaviour controls
  input wire logic [4:0] delay,
  input wire logic err_en,
  input wire logic [31:0] err_addr,
  input wire logic [7:0] iack_vec
);
  // ***************************************
  // answer logic
  // ***************************************
  logic [4:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 5'h00;
      rsp <= '0;
    end else begin
      rsp.valid <= 1'b0;
      rsp.err <= 1'b0;
      // idle data never repeats the last word
      rsp.data <= ~rsp.data;
      if (req.valid && !rsp.valid) begin
        if (cnt == delay) begin
          cnt <= 5'h00;
          rsp.valid <= 1'b1;
          rsp.err <= err_en && (req.addr == err_addr);
          rsp.data <= req.iack ? {24'h000000, iack_vec} : req.addr + 32'h1000_0000;
        end else begin
          cnt <= cnt + 5'h01;
        end
      end else begin
        // a request withdrawn by the unit is dropped
        cnt <= 5'h00;
      end
    end
  end
endmodule

// [dv/test_cpu_exception_reset_unit.sv]
/*
 * self-checking bench of the exception and reset unit over its register bus, pins and core ports.
 * assumes sys_bus_model answers reads with address + 0x1000_0000, or the acknowledge vector.
 */
`timescale 1ns/10ps
module test_cpu_exception_reset_unit;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic reset_in_n = 1'b1;
  logic [2:0] irq_level = 3'h0;
  exc_pkg::axil_req_t s_in = '0;
  exc_pkg::axil_rsp_t s_out;
  exc_pkg::bus_req_t bus_out;
  exc_pkg::bus_rsp_t bus_in;
  exc_pkg::core_in_t core_in = '0;
  exc_pkg::core_out_t core_out;
  logic [4:0] delay = 5'h01;
  logic err_en = 1'b0;
  logic [31:0] err_addr = 32'h0;
  logic [31:0] log_q[$];
  int fail_count = 0;
  int compares = 0;

  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (bus_in.valid) log_q.push_back(bus_out.addr);

  exc_unit u_exc_unit (.aclk(aclk), .aresetn(aresetn), .reset_in_n(reset_in_n), .irq_level(irq_level),
    .s_in(s_in), .s_out(s_out), .bus_out(bus_out), .bus_in(bus_in), .core_in(core_in), .core_out(core_out));
  sys_bus_model u_sys_bus_model (.aclk(aclk), .aresetn(aresetn), .req(bus_out), .rsp(bus_in),
    .delay(delay), .err_en(err_en), .err_addr(err_addr), .iack_vec(8'h40));

  // ***************************************
  // shared tasks
  // ***************************************
  task complete_run;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task timeout;
    fail_count++;
    $display("CHECK FAILED wait expected answer seen timeout");
    complete_run();
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_in.awvalid <= 1'b1;
    s_in.awaddr <= a;
    s_in.wvalid <= 1'b1;
    s_in.wdata <= d;
    s_in.wstrb <= 4'hf;
    s_in.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_out.awready) s_in.awvalid <= 1'b0;
      if (s_out.wready) s_in.wvalid <= 1'b0;
      if (s_out.bvalid) break;
    end
    if (n == 50) timeout();
    s_in.bready <= 1'b0;
    check("bresp", 32'(s_out.bresp), 32'(er));
  endtask

  task rd(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_in.arvalid <= 1'b1;
    s_in.araddr <= a;
    s_in.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_out.arready) s_in.arvalid <= 1'b0;
      if (s_out.rvalid) break;
    end
    if (n == 50) timeout();
    s_in.rready <= 1'b0;
    check(name, s_out.rdata, exp);
    check("rresp", 32'(s_out.rresp), 32'(er));
  endtask

  task wait_redirect;
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (core_out.redirect) break;
    end
    if (n == 200) timeout();
  endtask

  // fields: instr_done, unsupported_op, fault
  task pulse_core(input exc_pkg::core_in_t v);
    @(posedge aclk);
    core_in <= v;
    @(posedge aclk);
    core_in <= '0;
  endtask

  task pin_reset;
    @(posedge aclk);
    reset_in_n <= 1'b0;
    repeat (4) @(posedge aclk);
    check("in_reset", 32'(core_out.in_reset), 32'h1);
    check("halt_cleared", 32'(core_out.halted), 32'h0);
    log_q.delete();
    reset_in_n <= 1'b1;
    irq_level <= 3'h0;
  endtask

  task exc_check(input logic [7:0] v, input logic [31:0] pc);
    check("vector", 32'(core_out.vector), 32'(v));
    check("handler_pc", core_out.redirect_pc, pc);
  endtask

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_redirect();
    check("boot_read0", log_q[0], 32'h0);
    check("boot_read1", log_q[1], 32'h4);
    check("stack_ptr", core_out.stack_ptr, 32'h1000_0000);
    check("boot_pc", core_out.redirect_pc, 32'h1000_0004);
    rd("status", exc_pkg::A_STATUS, 32'h0000_2700, exc_pkg::RESP_OKAY);
    rd("vbase", exc_pkg::A_VBASE, 32'h0, exc_pkg::RESP_OKAY);
    rd("lmem", exc_pkg::A_LMEM, 32'h0, exc_pkg::RESP_OKAY);
    rd("unmapped", 8'h20, 32'h0, exc_pkg::RESP_SLVERR);
    wr(exc_pkg::A_SP, 32'h1234_5678, exc_pkg::RESP_OKAY);
    rd("sp_readonly", exc_pkg::A_SP, 32'h1000_0000, exc_pkg::RESP_OKAY);
    check("running", 32'(core_out.running), 32'h1);
    $display("test boot done");

    wr(exc_pkg::A_VBASE, 32'h0000_0100, exc_pkg::RESP_OKAY);
    wr(exc_pkg::A_LMEM, 32'h0000_000f, exc_pkg::RESP_OKAY);
    check("lmem_enable", 32'(core_out.lmem_enable), 32'hf);
    pulse_core(3'b010);
    wait_redirect();
    exc_check(8'h61, 32'h1000_0284);
    $display("test unsupported done");

    wr(exc_pkg::A_STATUS, 32'h0000_a700, exc_pkg::RESP_OKAY);
    pulse_core(3'b100);
    wait_redirect();
    exc_check(8'h09, 32'h1000_0124);
    $display("test trace done");

    wr(exc_pkg::A_STATUS, 32'h0000_2000, exc_pkg::RESP_OKAY);
    wr(exc_pkg::A_AVSEL, 32'h0000_0008, exc_pkg::RESP_OKAY);
    irq_level <= 3'h3;
    wait_redirect();
    irq_level <= 3'h0;
    exc_check(8'h1b, 32'h1000_016c);
    check("mask_auto", 32'(core_out.status_word[10:8]), 32'h3);
    @(posedge aclk);
    irq_level <= 3'h5;
    wait_redirect();
    irq_level <= 3'h0;
    exc_check(8'h40, 32'h1000_0200);
    check("supervisor", 32'(core_out.status_word[13]), 32'h1);
    $display("test interrupt done");

    delay <= 5'h14;
    pulse_core(3'b010);
    repeat (4) @(posedge aclk);
    pulse_core(3'b001);
    repeat (3) @(posedge aclk);
    check("fault_halt", 32'(core_out.halted), 32'h1);
    delay <= 5'h01;
    irq_level <= 3'h7;
    pulse_core(3'b100);
    repeat (30) @(posedge aclk);
    check("halt_holds", 32'(core_out.halted), 32'h1);
    rd("state_halt", exc_pkg::A_STATE, 32'h0001_6140, exc_pkg::RESP_OKAY);
    pin_reset();
    wait_redirect();
    rd("status_again", exc_pkg::A_STATUS, 32'h0000_2700, exc_pkg::RESP_OKAY);
    rd("vbase_again", exc_pkg::A_VBASE, 32'h0, exc_pkg::RESP_OKAY);
    check("lmem_off", 32'(core_out.lmem_enable), 32'h0);
    $display("test fault on fault done");

    err_en <= 1'b1;
    err_addr <= 32'h4;
    pin_reset();
    repeat (20) @(posedge aclk);
    check("boot_fault", 32'(core_out.halted), 32'h1);
    err_en <= 1'b0;
    pin_reset();
    wait_redirect();
    check("recovered", core_out.redirect_pc, 32'h1000_0004);
    $display("test boot fault done");

    wr(exc_pkg::A_STATUS, 32'h0000_2000, exc_pkg::RESP_OKAY);
    rd("avsel", exc_pkg::A_AVSEL, 32'h0000_0008, exc_pkg::RESP_OKAY);
    err_en <= 1'b1;
    err_addr <= 32'h6;
    irq_level <= 3'h6;
    wait_redirect();
    irq_level <= 3'h0;
    err_en <= 1'b0;
    exc_check(exc_pkg::VEC_SPURIOUS, 32'h1000_0060);
    check("mask_spurious", 32'(core_out.status_word[10:8]), 32'h6);
    pulse_core(3'b100);
    pulse_core(3'b001);
    wait_redirect();
    exc_check(exc_pkg::VEC_ACCESS, 32'h1000_0008);
    check("access_running", 32'(core_out.halted), 32'h0);
    $display("test spurious and access done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    timeout();
  end
endmodule
